/* verilog/pafs_top.sv */
// Pin function selection for the upper pins of the general port, with an APB register slave.
//
// The implementer's own choices: the APB register port and the register addresses.
`include "pafs_defs.svh"

// Summary of operation
// - High bit 14 routes top-byte strobe to pin23.
// - High bit 12 routes second-byte strobe to pin22.
// - High bit 10 routes upper column strobe.
// - High bit 8 routes lower column strobe.
// - Bits 7:6 pick gpio, bus ack, dma1 ack.
// - Bits 5:4 pick gpio, bus request, dma0 ack.
// - High bit 2 routes wait input on pin17.
// - High bit 0 routes address hold on pin16.
// - Reserved bits read zero, written zero.
// - Mode overrides: single chip gpio, romless strobes.
// - Bus and dma selections ignored per mode.
// - Low first resets 4000 in extended and romless, 0 in single chip.
// - Low second register resets to zero.
// - Soft resets and standby keep low registers.
// - Low first pins 15-8, second 7-0.
// - Low first bit 14 outputs system clock.
// - Low first bit 12 drives read strobe.
// - Low first bit 10 drives upper write.
// - Low first bit 8 drives lower write.
// - Low first bit 6 selects pin11 function.
// - High register resets zero, kept otherwise.
module pafs_top
  import pafs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  op_mode,
  input  wire logic        system_clock_out,
  input  wire logic        top_byte_write_strobe,
  input  wire logic        second_byte_write_strobe,
  input  wire logic        upper_column_strobe,
  input  wire logic        lower_column_strobe,
  input  wire logic        bus_grant_ack,
  input  wire logic        dma1_request_ack,
  input  wire logic        dma0_request_ack,
  input  wire logic        address_hold_out,
  input  wire logic        read_strobe,
  input  wire logic        upper_half_write_strobe,
  input  wire logic        lower_half_write_strobe,
  input  wire logic        chip_select1,
  output logic             bus_request_in,
  output logic             wait_request_in,
  input  wire logic [23:11] pin_in,
  output logic      [23:11] pin_out,
  output logic      [23:11] pin_oe_n
);

  logic [15:0]  high_function_control_ff;
  logic [15:0]  low_first_function_control_ff;
  logic [15:0]  low_second_function_control_ff;
  logic [23:11] data_ff;
  logic [23:11] dir_ff;
  logic [23:11] pin_meta_ff;
  logic [23:11] pin_sync_ff;
  logic [1:0]   mode_meta_ff;
  logic [1:0]   mode_sync_ff;
  logic         low1_init_pending_ff;
  logic [1:0]   low1_init_cnt_ff;
  logic [31:0]  prdata_ff;
  pafs_mode_t   mode;
  pafs_sel2_t   sel19;
  pafs_sel2_t   sel18;
  logic [23:11] alt_en;
  logic [23:11] alt_val;
  logic         wr_acc;
  logic         rd_acc;
  logic         addr_ok;
  logic [31:0]  nxt_rdata;

  // Merge a write into a 16-bit register by byte lane, keeping reserved bits at zero.
  function automatic logic [15:0] merge16(input logic [15:0] cur,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st,
                                          input logic [15:0] wmask);
    logic [15:0] v;
    v = cur;
    if (st[0]) begin
      v[7:0] = wd[7:0];
    end
    if (st[1]) begin
      v[15:8] = wd[15:8];
    end
    return v & wmask;
  endfunction : merge16

  assign wr_acc = clk_en && psel && penable && pwrite;
  assign rd_acc = clk_en && psel && penable && !pwrite;
  assign addr_ok = (paddr == `PAFS_OFS_HIGH) || (paddr == `PAFS_OFS_LOW1) ||
                   (paddr == `PAFS_OFS_LOW2) || (paddr == `PAFS_OFS_MODE) ||
                   (paddr == `PAFS_OFS_DATA) || (paddr == `PAFS_OFS_DIR) ||
                   (paddr == `PAFS_OFS_PIN);

  // Pins and the mode straps come from outside the clock domain, so they are synchronised.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_ff  <= '0;
      pin_sync_ff  <= '0;
      mode_meta_ff <= 2'h0;
      mode_sync_ff <= 2'h0;
    end else if (clk_en) begin
      pin_meta_ff  <= pin_in;
      pin_sync_ff  <= pin_meta_ff;
      mode_meta_ff <= op_mode;
      mode_sync_ff <= mode_meta_ff;
    end
  end

  // An unknown mode code is treated as single chip, the safest choice for the pins.
  always_comb begin
    if (mode_sync_ff == 2'b11) begin
      mode = PAFS_MODE_SINGLE;
    end else begin
      mode = pafs_mode_t'(mode_sync_ff);
    end
  end

  // Only power-on reset (presetn) clears the control registers; other resets never reach here.
  // High register reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_function_control_ff <= `PAFS_HIGH_RST;
    end else if (wr_acc && paddr == `PAFS_OFS_HIGH) begin
      high_function_control_ff <= merge16(high_function_control_ff, pwdata, pstrb,
                                          `PAFS_HIGH_WMASK);
    end
  end

  // The strap is not known until synchronised, so the extended value is loaded after release.
  // The synchroniser still holds its reset value for two edges, so a count waits them out.
  // Mode dependent init
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_first_function_control_ff <= `PAFS_LOW1_RST_SC;
      low1_init_pending_ff          <= 1'b1;
      low1_init_cnt_ff              <= 2'h0;
    end else if (clk_en) begin
      if (low1_init_pending_ff && low1_init_cnt_ff != 2'h2) begin
        low1_init_cnt_ff <= low1_init_cnt_ff + 2'h1;
      end else if (low1_init_pending_ff) begin
        low1_init_pending_ff <= 1'b0;
        if (mode != PAFS_MODE_SINGLE) begin
          low_first_function_control_ff <= `PAFS_LOW1_RST_EXT;
        end
      end else if (wr_acc && paddr == `PAFS_OFS_LOW1) begin
        low_first_function_control_ff <= merge16(low_first_function_control_ff, pwdata,
                                                 pstrb, `PAFS_LOW1_WMASK);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_second_function_control_ff <= `PAFS_LOW2_RST;
    end else if (wr_acc && paddr == `PAFS_OFS_LOW2) begin
      low_second_function_control_ff <= merge16(low_second_function_control_ff, pwdata,
                                                pstrb, `PAFS_LOW2_WMASK);
    end
  end

  // General I/O data and direction for the pins handled here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ff <= '0;
      dir_ff  <= '0;
    end else if (wr_acc && paddr == `PAFS_OFS_DATA) begin
      data_ff <= pwdata[23:11];
    end else if (wr_acc && paddr == `PAFS_OFS_DIR) begin
      dir_ff <= pwdata[23:11];
    end
  end

  assign sel19 = pafs_sel2_t'(high_function_control_ff[`PAFS_B_PIN19_HI:`PAFS_B_PIN19_LO]);
  assign sel18 = pafs_sel2_t'(high_function_control_ff[`PAFS_B_PIN18_HI:`PAFS_B_PIN18_LO]);

  // Alternate function selection per pin, then the mode override on top.
  always_comb begin
    alt_en  = '0;
    alt_val = '0;
    alt_en[23]  = high_function_control_ff[`PAFS_B_PIN23];
    alt_val[23] = top_byte_write_strobe;
    alt_en[22]  = high_function_control_ff[`PAFS_B_PIN22];
    alt_val[22] = second_byte_write_strobe;
    alt_en[21]  = high_function_control_ff[`PAFS_B_PIN21];
    alt_val[21] = upper_column_strobe;
    alt_en[20]  = high_function_control_ff[`PAFS_B_PIN20];
    alt_val[20] = lower_column_strobe;
    unique case (sel19)
      PAFS_SEL2_ALT1: begin
        alt_en[19]  = 1'b1;
        alt_val[19] = bus_grant_ack;
      end
      PAFS_SEL2_ALT2: begin
        alt_en[19]  = 1'b1;
        alt_val[19] = dma1_request_ack;
      end
      PAFS_SEL2_GPIO, PAFS_SEL2_RSVD: begin
        alt_en[19] = 1'b0;
      end
    endcase
    alt_en[18]  = (sel18 == PAFS_SEL2_ALT2);
    alt_val[18] = dma0_request_ack;
    alt_en[16]  = high_function_control_ff[`PAFS_B_PIN16];
    alt_val[16] = address_hold_out;
    alt_en[15]  = low_first_function_control_ff[`PAFS_B_PIN15];
    alt_val[15] = system_clock_out;
    alt_en[14]  = low_first_function_control_ff[`PAFS_B_PIN14];
    alt_val[14] = read_strobe;
    alt_en[13]  = low_first_function_control_ff[`PAFS_B_PIN13];
    alt_val[13] = upper_half_write_strobe;
    alt_en[12]  = low_first_function_control_ff[`PAFS_B_PIN12];
    alt_val[12] = lower_half_write_strobe;
    alt_en[11]  = low_first_function_control_ff[`PAFS_B_PIN11];
    alt_val[11] = chip_select1;
    if (mode == PAFS_MODE_SINGLE) begin
      alt_en[23:12] = '0;
      alt_en[11]    = 1'b0;
      alt_en[19:18] = 2'b00;
    end else if (mode == PAFS_MODE_ROMLESS) begin
      alt_en[23] = 1'b1;
      alt_en[22] = 1'b1;
      alt_en[14] = 1'b1;
      alt_en[13] = 1'b1;
      alt_en[12] = 1'b1;
      alt_en[11] = 1'b1;
    end
  end

  always_comb begin
    for (int i = 11; i <= 23; i++) begin
      pin_out[i]  = alt_en[i] ? alt_val[i] : data_ff[i];
      pin_oe_n[i] = !(alt_en[i] || dir_ff[i]);
    end
    // Input-only functions release the pin whatever the direction bit says.
    if (mode != PAFS_MODE_SINGLE && sel18 == PAFS_SEL2_ALT1) begin
      pin_oe_n[18] = 1'b1;
    end
    if (mode != PAFS_MODE_SINGLE && high_function_control_ff[`PAFS_B_PIN17]) begin
      pin_oe_n[17] = 1'b1;
    end
  end

  // Input functions idle high (inactive) when not selected, so the bus logic sees no request.
  // Bus request and wait request inputs
  assign bus_request_in  = (mode != PAFS_MODE_SINGLE && sel18 == PAFS_SEL2_ALT1) ?
                           pin_sync_ff[18] : 1'b1;
  assign wait_request_in = (mode != PAFS_MODE_SINGLE &&
                            high_function_control_ff[`PAFS_B_PIN17]) ? pin_sync_ff[17] : 1'b1;

  // Read mux; reserved bits come back as zero because the masks keep them clear.
  always_comb begin
    nxt_rdata = 32'h0;
    unique case (paddr)
      `PAFS_OFS_HIGH: nxt_rdata[15:0] = high_function_control_ff;
      `PAFS_OFS_LOW1: nxt_rdata[15:0] = low_first_function_control_ff;
      `PAFS_OFS_LOW2: nxt_rdata[15:0] = low_second_function_control_ff;
      `PAFS_OFS_MODE: nxt_rdata[1:0]  = mode;
      `PAFS_OFS_DATA: nxt_rdata[23:11] = data_ff;
      `PAFS_OFS_DIR:  nxt_rdata[23:11] = dir_ff;
      `PAFS_OFS_PIN:  nxt_rdata[23:11] = pin_sync_ff;
      default:        nxt_rdata = 32'h0;
    endcase
  end

  // Read data is registered at the access edge and held until the next read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else if (rd_acc) begin
      prdata_ff <= nxt_rdata;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = clk_en;
  assign pslverr = psel && penable && !addr_ok;

endmodule : pafs_top

/* verilog/pafs_defs.svh */
// Register offsets, field positions and reset values for the port pin function selector.
`ifndef PAFS_DEFS_SVH
`define PAFS_DEFS_SVH

`define PAFS_OFS_HIGH        12'h000
`define PAFS_OFS_LOW1        12'h004
`define PAFS_OFS_LOW2        12'h008
`define PAFS_OFS_MODE        12'h00c
`define PAFS_OFS_DATA        12'h010
`define PAFS_OFS_DIR         12'h014
`define PAFS_OFS_PIN         12'h018

`define PAFS_HIGH_WMASK      16'h55f5
`define PAFS_LOW1_WMASK      16'h555f
`define PAFS_LOW2_WMASK      16'hfd75
`define PAFS_LOW1_RST_EXT    16'h4000
`define PAFS_LOW1_RST_SC     16'h0000
`define PAFS_HIGH_RST        16'h0000
`define PAFS_LOW2_RST        16'h0000

`define PAFS_B_PIN23         14
`define PAFS_B_PIN22         12
`define PAFS_B_PIN21         10
`define PAFS_B_PIN20         8
`define PAFS_B_PIN19_HI      7
`define PAFS_B_PIN19_LO      6
`define PAFS_B_PIN18_HI      5
`define PAFS_B_PIN18_LO      4
`define PAFS_B_PIN17         2
`define PAFS_B_PIN16         0
`define PAFS_B_PIN15         14
`define PAFS_B_PIN14         12
`define PAFS_B_PIN13         10
`define PAFS_B_PIN12         8
`define PAFS_B_PIN11         6

`endif

/* verilog/pafs_pkg.sv */
// Types shared by the port pin function selector.
package pafs_pkg;
  // Operating mode of the chip, as seen by the pin multiplexer.
  typedef enum logic [1:0] {
    PAFS_MODE_SINGLE   = 2'b00,
    PAFS_MODE_EXTENDED = 2'b01,
    PAFS_MODE_ROMLESS  = 2'b10
  } pafs_mode_t;

  typedef enum logic [1:0] {
    PAFS_SEL2_GPIO = 2'b00,
    PAFS_SEL2_ALT1 = 2'b01,
    PAFS_SEL2_ALT2 = 2'b10,
    PAFS_SEL2_RSVD = 2'b11
  } pafs_sel2_t;
endpackage : pafs_pkg

/* dv/pafs_properties.sv */
// Checker that watches the pin function selector at its ports.
module pafs_properties (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         clk_en,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [3:0]   pstrb,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic [1:0]   op_mode,
  input wire logic         system_clock_out,
  input wire logic         top_byte_write_strobe,
  input wire logic         dma1_request_ack,
  input wire logic         read_strobe,
  input wire logic         chip_select1,
  input wire logic         bus_request_in,
  input wire logic         wait_request_in,
  input wire logic [23:11] pin_out,
  input wire logic [23:11] pin_oe_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [1:0] mode_ff;
  logic [2:0] age_ff;
  logic       wr_hi;
  logic       ext_ok;
  // Mode age counts enabled edges since the strap moved, since the pins see it only after sync.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= 2'h0;
      age_ff  <= 3'h0;
    end else if (op_mode != mode_ff) begin
      mode_ff <= op_mode;
      age_ff  <= 3'h0;
    end else if (clk_en && age_ff != 3'h7) begin
      age_ff <= age_ff + 3'h1;
    end
  end
  // Completed write of the upper register with both low lanes, and a settled extended mode.
  assign wr_hi  = psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[1] && pstrb[0];
  assign ext_ok = mode_ff == 2'b01 && age_ff >= 3'h5;
  a_top_byte_route: assert property (
    wr_hi && pwdata[14] && ext_ok |=> !pin_oe_n[23] && pin_out[23] == top_byte_write_strobe)
    else $error("top byte strobe not on pin 23");
  a_dma1_route: assert property (
    wr_hi && pwdata[7:6] == 2'b10 && ext_ok |=> !pin_oe_n[19] && pin_out[19] == dma1_request_ack)
    else $error("dma1 acknowledge not on pin 19");
  a_wait_release: assert property (
    wr_hi && pwdata[2] && ext_ok |=> pin_oe_n[17])
    else $error("wait input pin still driven");
  a_single_idle: assert property (
    mode_ff == 2'b00 && age_ff >= 3'h5 |-> bus_request_in && wait_request_in)
    else $error("bus inputs not idle in single chip mode");
  a_romless_force: assert property (
    mode_ff == 2'b10 && age_ff >= 3'h5 |-> !pin_oe_n[23] && !pin_oe_n[11]
      && pin_out[14] == read_strobe && pin_out[11] == chip_select1)
    else $error("romless mode strobes not forced");
  a_clock_reset: assert property (
    ($rose(presetn) && op_mode == 2'b01 ##1 (op_mode == 2'b01 && clk_en && !psel) [*6])
      |-> !pin_oe_n[15] && pin_out[15] == system_clock_out)
    else $error("clock pin not selected after reset");
  a_reset_inputs: assert property (
    $rose(presetn) |-> &pin_oe_n)
    else $error("pin driven right after reset");
  a_reserved_zero: assert property (
    psel && penable && pready && !pwrite && paddr == 12'h000 |=> (prdata & 32'hffffaa0a) == 32'h0)
    else $error("reserved upper bits read nonzero");
  cover property (wr_hi && ext_ok);
  cover property (mode_ff == 2'b10 && age_ff == 3'h7);
  cover property (psel && penable && pready && !pwrite && paddr == 12'h004);
endmodule : pafs_properties

bind pafs_top pafs_properties pafs_properties_inst (.*);

/* dv/pafs_pins.sv */
// Board wires and far-side devices on the upper port pins.
module pafs_pins (
  input  wire logic [23:11] pin_out,
  input  wire logic [23:11] pin_oe_n,
  input  wire logic [23:11] far_en,
  input  wire logic [23:11] far_val,
  output logic      [23:11] pin_in
);
  // The device wins when it drives; an undriven wire floats up to its pull-up.
  always_comb begin
    for (int i = 11; i <= 23; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (far_en[i] ? far_val[i] : 1'b1);
    end
  end
endmodule : pafs_pins

/* dv/port_a_pin_function_select_test.sv */
// Self-checking bench for the port pin function selector.
module port_a_pin_function_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic         pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic [3:0]   pstrb;
  logic [1:0]   op_mode;
  logic [12:0]  alt_v;
  logic         bus_request_in, wait_request_in, last_err;
  logic [23:11] pin_in, pin_out, pin_oe_n, far_en, far_val;
  int           fails, checks;
  // Device and board model; alternate sources come from one vector.
  pafs_top pafs_top_inst (.*, .system_clock_out(alt_v[0]), .top_byte_write_strobe(alt_v[1]),
    .second_byte_write_strobe(alt_v[2]), .upper_column_strobe(alt_v[3]),
    .lower_column_strobe(alt_v[4]), .bus_grant_ack(alt_v[5]), .dma1_request_ack(alt_v[6]),
    .dma0_request_ack(alt_v[7]), .address_hold_out(alt_v[8]), .read_strobe(alt_v[9]),
    .upper_half_write_strobe(alt_v[10]), .lower_half_write_strobe(alt_v[11]),
    .chip_select1(alt_v[12]));
  pafs_pins pafs_pins_inst (.*);
  // Free-running clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : check
  // Pin state as {output enable low-active, output level}.
  task automatic pin(input int p, input logic [1:0] e);
    check($sformatf("pin%0d", p), {30'h0, e}, {30'h0, pin_oe_n[p], pin_out[p]});
  endtask : pin
  // Toggle one source both ways so a stuck pin cannot match by luck.
  task automatic routed(input int p, input int k);
    for (int v = 0; v < 2; v++) begin
      alt_v[k] <= v[0];
      @(posedge pclk);
      pin(p, {1'b0, v[0]});
    end
  endtask : routed
  // One transfer; an idle edge follows so no signal is assigned twice in a time step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    q = prdata;
    if (n >= 50) begin
      fails++;
      print_verdict();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    check($sformatf("reg_%h", a), e, q);
  endtask : rd
  // Upper register masks, strobe routing, acknowledge codes and released inputs.
  task automatic s_high();
    wr(12'h000, 32'h0000ffff);
    rd(12'h000, 32'h000055f5);
    check("slverr_ok", 32'h0, {31'h0, last_err});
    rd(12'h100, 32'h0);
    check("slverr_bad", 32'h1, {31'h0, last_err});
    routed(23, 1);
    routed(22, 2);
    routed(21, 3);
    routed(20, 4);
    routed(16, 8);
    pin(19, 2'b10);
    wr(12'h000, 32'h00000054);
    far_en[18:17] <= 2'b11;
    routed(19, 5);
    @(posedge pclk);
    check("req_lo", 32'h0, {31'h0, bus_request_in});
    check("wait_lo", 32'h0, {31'h0, wait_request_in});
    far_val[18:17] <= 2'b11;
    repeat (4) @(posedge pclk);
    check("req_hi", 32'h1, {31'h0, bus_request_in});
    wr(12'h000, 32'h000000a0);
    routed(19, 6);
    routed(18, 7);
  endtask : s_high
  // Lower registers: pins 15 to 11 and the second register masks.
  task automatic s_low1();
    wr(12'h004, 32'h0000ffff);
    rd(12'h004, 32'h0000555f);
    routed(15, 0);
    routed(14, 9);
    routed(13, 10);
    routed(12, 11);
    routed(11, 12);
    wr(12'h014, 32'h00ffffff);
    routed(15, 0);
    wr(12'h014, 32'h0);
    wr(12'h008, 32'h0000ffff);
    rd(12'h008, 32'h0000fd75);
  endtask : s_low1
  // Single chip mode drops bus functions; romless mode forces strobes with fields at zero.
  task automatic s_modes();
    far_val[18] <= 1'b0;
    op_mode <= 2'b00;
    wr(12'h000, 32'h00004050);
    repeat (6) @(posedge pclk);
    pin(23, 2'b10);
    pin(19, 2'b10);
    check("req_single", 32'h1, {31'h0, bus_request_in});
    wr(12'h000, 32'h0);
    wr(12'h004, 32'h0);
    op_mode <= 2'b10;
    repeat (8) @(posedge pclk);
    routed(23, 1);
    routed(14, 9);
    routed(11, 12);
    op_mode <= 2'b01;
    repeat (8) @(posedge pclk);
  endtask : s_modes
  // A frozen clock, as in standby, keeps the register contents.
  task automatic s_keep();
    wr(12'h000, 32'h00005555);
    clk_en <= 1'b0;
    repeat (6) @(posedge pclk);
    clk_en <= 1'b1;
    rd(12'h000, 32'h00005555);
    rd(12'h008, 32'h0000fd75);
  endtask : s_keep
  // Power-on reset in single chip mode clears everything.
  task automatic s_reset2();
    op_mode <= 2'b00;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(12'h004, 32'h0);
    rd(12'h000, 32'h0);
    rd(12'h008, 32'h0);
  endtask : s_reset2
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  // Reset in extended mode, then the scenarios in turn.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, alt_v, far_en, far_val} = '0;
    {fails, checks} = '0;
    clk_en = 1'b1;
    pstrb = 4'hf;
    op_mode = 2'b01;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h00004000);
    routed(15, 0);
    pin(23, 2'b10);
    s_high();
    s_low1();
    s_modes();
    s_keep();
    s_reset2();
    print_verdict();
  end
endmodule : port_a_pin_function_select_test
